// *** rtl/owf_pkg.sv ***
// owf_pkg: register map, field layout, reset values and fetch states of the
// second overlay window fetch address generator.
// assumes a 16-bit register port with byte addresses as printed.
package owf_pkg;
    localparam int unsigned OWF_AW = 10;
    localparam int unsigned OWF_DW = 16;
    localparam int unsigned OWF_MEM_AW = 20;

    localparam logic [OWF_AW-1:0] OWF_SCR_START_LO_OFS = 10'h2b0;
    localparam logic [OWF_AW-1:0] OWF_SCR_START_HI_OFS = 10'h2b2;
    localparam logic [OWF_AW-1:0] OWF_SCR_END_LO_OFS = 10'h2b4;
    localparam logic [OWF_AW-1:0] OWF_SCR_END_HI_OFS = 10'h2b6;
    localparam logic [OWF_AW-1:0] OWF_DISP_START_LO_OFS = 10'h2b8;
    localparam logic [OWF_AW-1:0] OWF_DISP_START_HI_OFS = 10'h2ba;
    localparam logic [OWF_AW-1:0] OWF_LINE_OFS_OFS = 10'h2bc;
    localparam logic [OWF_AW-1:0] OWF_SRC_WIDTH_OFS = 10'h2be;

    // writable field masks per register
    localparam logic [OWF_DW-1:0] OWF_SCR_LO_MASK = 16'hfffc;
    localparam logic [OWF_DW-1:0] OWF_HI_MASK = 16'h000f;
    localparam logic [OWF_DW-1:0] OWF_DISP_LO_MASK = 16'hfffe;
    localparam logic [OWF_DW-1:0] OWF_LINE_OFS_MASK = 16'h0ffe;
    localparam logic [OWF_DW-1:0] OWF_SRC_WIDTH_MASK = 16'h01fe;

    // reset values
    localparam logic [OWF_DW-1:0] OWF_SCR_START_LO_RST = 16'h0000;
    localparam logic [OWF_DW-1:0] OWF_SCR_START_HI_RST = 16'h0000;
    localparam logic [OWF_DW-1:0] OWF_SCR_END_LO_RST = 16'hfffc;
    localparam logic [OWF_DW-1:0] OWF_SCR_END_HI_RST = 16'h000f;
    localparam logic [OWF_DW-1:0] OWF_DISP_START_LO_RST = 16'h0000;
    localparam logic [OWF_DW-1:0] OWF_DISP_START_HI_RST = 16'h0000;
    localparam logic [OWF_DW-1:0] OWF_LINE_OFS_RST = 16'h0000;
    localparam logic [OWF_DW-1:0] OWF_SRC_WIDTH_RST = 16'h0000;

    // one pixel is 16 bits, i.e. two bytes of display buffer
    localparam logic [OWF_MEM_AW-1:0] OWF_PIXEL_BYTES = 20'h00002;

    typedef enum logic [2:0] {
        OWF_IDLE = 3'b001,
        OWF_LINE = 3'b010,
        OWF_WAIT = 3'b100
    } owf_state_t;
endpackage

// *** rtl/owf_wrap_step.sv ***
// owf_wrap_step: computes the next fetch address from a base and a step,
// wrapping to the scroll start once the result passes the scroll end.
// assumes purely combinational use on the fetch clock.
`timescale 1ns/100ps
`default_nettype none
module owf_wrap_step
    import owf_pkg::*;
(
    input wire logic [OWF_MEM_AW-1:0] base_addr, // address to step from
    input wire logic [OWF_MEM_AW-1:0] step, // bytes to add
    input wire logic [OWF_MEM_AW-1:0] scroll_start, // wrap target
    input wire logic [OWF_MEM_AW-1:0] scroll_end, // last legal address
    output logic [OWF_MEM_AW-1:0] next_addr, // stepped address after wrap
    output logic wrapped // wrap was taken
);
    wire logic [OWF_MEM_AW:0] sum_wide;
    // a carry out of the 20-bit space also counts as past the end
    assign sum_wide = {1'b0, base_addr} + {1'b0, step};
    assign wrapped = sum_wide > {1'b0, scroll_end};
    assign next_addr = wrapped ? scroll_start : sum_wide[OWF_MEM_AW-1:0];
endmodule
`default_nettype wire

// *** rtl/owf_fetch_addr.sv ***
// owf_fetch_addr: register file and fetch address generator of the second
// overlay window.
// assumes the display pipe gives a frame start pulse, a line start pulse and a
// pixel request pulse on clk; the register port is a plain 16-bit slave.
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - scroll start address bits 19:2 held, split low/high
// - address past scroll end reloads scroll start
// - scroll end address bits 19:2 held, split low/high
// - display start address bits 19:1 held
// - line offset 11:1 steps address per line
// - source width pixels from bits 8:1
module owf_fetch_addr
    import owf_pkg::*;
(
    input wire logic clk, // 125 MHz controller clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic [owf_pkg::OWF_AW-1:0] reg_addr, // register byte address
    input wire logic [owf_pkg::OWF_DW-1:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [owf_pkg::OWF_DW-1:0] reg_rdata, // read data, cycle after strobe
    input wire logic frame_start, // pulse: new window frame
    input wire logic line_start, // pulse: begin fetching a window line
    input wire logic pixel_req, // pulse: one pixel fetched
    output logic [owf_pkg::OWF_MEM_AW-1:0] fetch_addr, // display buffer read address
    output logic fetch_valid, // fetch_addr is a live pixel address
    output logic line_done, // pulse: last pixel of the line taken
    output logic scroll_wrap // pulse: address wrapped to scroll start
);
    import owf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register file
    logic [OWF_DW-1:0] scr_start_lo_reg;
    logic [OWF_DW-1:0] scr_start_hi_reg;
    logic [OWF_DW-1:0] scr_end_lo_reg;
    logic [OWF_DW-1:0] scr_end_hi_reg;
    logic [OWF_DW-1:0] disp_start_lo_reg;
    logic [OWF_DW-1:0] disp_start_hi_reg;
    logic [OWF_DW-1:0] line_ofs_reg;
    logic [OWF_DW-1:0] src_width_reg;

    wire logic wr_scr_start_lo;
    wire logic wr_scr_start_hi;
    wire logic wr_scr_end_lo;
    wire logic wr_scr_end_hi;
    wire logic wr_disp_start_lo;
    wire logic wr_disp_start_hi;
    wire logic wr_line_ofs;
    wire logic wr_src_width;

    // each register answers at exactly one even byte address
    assign wr_scr_start_lo = reg_wr && (reg_addr == OWF_SCR_START_LO_OFS);
    assign wr_scr_start_hi = reg_wr && (reg_addr == OWF_SCR_START_HI_OFS);
    assign wr_scr_end_lo = reg_wr && (reg_addr == OWF_SCR_END_LO_OFS);
    assign wr_scr_end_hi = reg_wr && (reg_addr == OWF_SCR_END_HI_OFS);
    assign wr_disp_start_lo = reg_wr && (reg_addr == OWF_DISP_START_LO_OFS);
    assign wr_disp_start_hi = reg_wr && (reg_addr == OWF_DISP_START_HI_OFS);
    assign wr_line_ofs = reg_wr && (reg_addr == OWF_LINE_OFS_OFS);
    assign wr_src_width = reg_wr && (reg_addr == OWF_SRC_WIDTH_OFS);

    // unused bits never store, so they read back as zero
    // resets follow the register table; only scroll end comes up non-zero
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            scr_start_lo_reg <= OWF_SCR_START_LO_RST;
        else if (wr_scr_start_lo)
            scr_start_lo_reg <= reg_wdata & OWF_SCR_LO_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            scr_start_hi_reg <= OWF_SCR_START_HI_RST;
        else if (wr_scr_start_hi)
            scr_start_hi_reg <= reg_wdata & OWF_HI_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            scr_end_lo_reg <= OWF_SCR_END_LO_RST;
        else if (wr_scr_end_lo)
            scr_end_lo_reg <= reg_wdata & OWF_SCR_LO_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            scr_end_hi_reg <= OWF_SCR_END_HI_RST;
        else if (wr_scr_end_hi)
            scr_end_hi_reg <= reg_wdata & OWF_HI_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            disp_start_lo_reg <= OWF_DISP_START_LO_RST;
        else if (wr_disp_start_lo)
            disp_start_lo_reg <= reg_wdata & OWF_DISP_LO_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            disp_start_hi_reg <= OWF_DISP_START_HI_RST;
        else if (wr_disp_start_hi)
            disp_start_hi_reg <= reg_wdata & OWF_HI_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            line_ofs_reg <= OWF_LINE_OFS_RST;
        else if (wr_line_ofs)
            line_ofs_reg <= reg_wdata & OWF_LINE_OFS_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            src_width_reg <= OWF_SRC_WIDTH_RST;
        else if (wr_src_width)
            src_width_reg <= reg_wdata & OWF_SRC_WIDTH_MASK;
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data stands only in the cycle after the strobe
    logic [OWF_DW-1:0] rd_mux;
    logic [OWF_DW-1:0] reg_rdata_reg;

    always_comb
    begin
        case (reg_addr)
            OWF_SCR_START_LO_OFS: rd_mux = scr_start_lo_reg;
            OWF_SCR_START_HI_OFS: rd_mux = scr_start_hi_reg;
            OWF_SCR_END_LO_OFS: rd_mux = scr_end_lo_reg;
            OWF_SCR_END_HI_OFS: rd_mux = scr_end_hi_reg;
            OWF_DISP_START_LO_OFS: rd_mux = disp_start_lo_reg;
            OWF_DISP_START_HI_OFS: rd_mux = disp_start_hi_reg;
            OWF_LINE_OFS_OFS: rd_mux = line_ofs_reg;
            OWF_SRC_WIDTH_OFS: rd_mux = src_width_reg;
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            reg_rdata_reg <= 16'h0000;
        else
            reg_rdata_reg <= reg_rd ? rd_mux : 16'h0000;
    end
    assign reg_rdata = reg_rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // assembled addresses
    // no shadowing: each half takes effect at its own write, so software
    // updates both halves before the next frame start
    wire logic [OWF_MEM_AW-1:0] scroll_start;
    wire logic [OWF_MEM_AW-1:0] scroll_end;
    wire logic [OWF_MEM_AW-1:0] disp_start;
    wire logic [OWF_MEM_AW-1:0] line_step;
    wire logic [7:0] src_pixels;

    assign scroll_start = {scr_start_hi_reg[3:0], scr_start_lo_reg[15:2], 2'b00};
    assign scroll_end = {scr_end_hi_reg[3:0], scr_end_lo_reg[15:2], 2'b00};
    assign disp_start = {disp_start_hi_reg[3:0], disp_start_lo_reg[15:1], 1'b0};
    assign line_step = {8'h00, line_ofs_reg[11:1], 1'b0};
    assign src_pixels = src_width_reg[8:1];

    ////////////////////////////////////////////////////////////////////////////
    // fetch sequencer
    owf_state_t state_reg;
    owf_state_t state_next;
    logic [OWF_MEM_AW-1:0] line_base_reg;
    logic [OWF_MEM_AW-1:0] addr_reg;
    logic [7:0] pix_cnt_reg;
    logic valid_reg;
    logic line_done_reg;
    logic wrap_reg;

    wire logic [OWF_MEM_AW-1:0] pix_next_addr;
    wire logic pix_wrap;
    wire logic [OWF_MEM_AW-1:0] line_next_addr;
    wire logic line_wrap;
    wire logic last_pix;

    // next pixel within the line
    owf_wrap_step u_pix_step (
        .base_addr(addr_reg),
        .step(OWF_PIXEL_BYTES),
        .scroll_start(scroll_start),
        .scroll_end(scroll_end),
        .next_addr(pix_next_addr),
        .wrapped(pix_wrap)
    );

    // start of the following line
    owf_wrap_step u_line_step (
        .base_addr(line_base_reg),
        .step(line_step),
        .scroll_start(scroll_start),
        .scroll_end(scroll_end),
        .next_addr(line_next_addr),
        .wrapped(line_wrap)
    );

    // a zero width still yields one pixel, so the line always ends
    assign last_pix = (pix_cnt_reg + 8'h01 >= src_pixels);

    // frame start outranks every other event; line and pixel events are
    // kept apart by the state each of them needs
    wire logic do_frame;
    wire logic do_first_line;
    wire logic do_next_line;
    wire logic do_pixel;
    wire logic do_advance;
    wire logic do_finish;

    assign do_frame = frame_start;
    assign do_first_line = !frame_start && line_start && (state_reg == OWF_IDLE);
    assign do_next_line = !frame_start && line_start && (state_reg == OWF_WAIT);
    assign do_pixel = !frame_start && pixel_req && (state_reg == OWF_LINE);
    assign do_advance = do_pixel && !last_pix;
    assign do_finish = do_pixel && last_pix;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            OWF_IDLE:
                if (line_start)
                    state_next = OWF_LINE;
            OWF_LINE:
                if (pixel_req && last_pix)
                    state_next = OWF_WAIT;
            OWF_WAIT:
                if (line_start)
                    state_next = OWF_LINE;
            default:
                state_next = OWF_IDLE;
        endcase
        if (frame_start)
            state_next = OWF_IDLE;
    end

    // frame start returns to idle from any state
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            state_reg <= OWF_IDLE;
        else
            state_reg <= state_next;
    end

    // line base remembers where the current line began, so the offset is
    // added to the line start and not to the last pixel address
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            line_base_reg <= 20'h00000;
        else if (do_frame)
            line_base_reg <= disp_start;
        else if (do_next_line)
            line_base_reg <= line_next_addr;
    end

    // the first line of a frame starts at the display start itself
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            addr_reg <= 20'h00000;
        else if (do_frame)
            addr_reg <= disp_start;
        else if (do_first_line)
            addr_reg <= line_base_reg;
        else if (do_next_line)
            addr_reg <= line_next_addr;
        else if (do_advance)
            addr_reg <= pix_next_addr;
    end

    // the count restarts with each line; after the last pixel it rests
    // until the next line start
    always_ff @(posedge clk)
    begin
        if (sys_rst || do_frame || do_first_line || do_next_line)
            pix_cnt_reg <= 8'h00;
        else if (do_advance)
            pix_cnt_reg <= pix_cnt_reg + 8'h01;
    end

    // a frame start closes any line that was still open
    always_ff @(posedge clk)
    begin
        if (sys_rst || do_frame || do_finish)
            valid_reg <= 1'b0;
        else if (do_first_line || do_next_line)
            valid_reg <= 1'b1;
    end

    // one-cycle pulse after the last pixel of a line
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            line_done_reg <= 1'b0;
        else
            line_done_reg <= do_finish;
    end

    // wrap is judged on the stepped address, so no stepped address past the scroll
    // end is ever put out; the pulse stands one cycle
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            wrap_reg <= 1'b0;
        else if (do_next_line)
            wrap_reg <= line_wrap;
        else if (do_advance)
            wrap_reg <= pix_wrap;
        else
            wrap_reg <= 1'b0;
    end

    assign fetch_addr = addr_reg;
    assign fetch_valid = valid_reg;
    assign line_done = line_done_reg;
    assign scroll_wrap = wrap_reg;
endmodule
`default_nettype wire

// *** dv/owf_fetch_addr_chk.sv ***
// owf_fetch_addr_chk: port assertions of the overlay fetch address block.
// assumes it is bound onto owf_fetch_addr, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module owf_fetch_addr_chk
    import owf_pkg::*;
(
    input wire logic clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic [owf_pkg::OWF_AW-1:0] reg_addr, // address
    input wire logic [owf_pkg::OWF_DW-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [owf_pkg::OWF_DW-1:0] reg_rdata, // read data
    input wire logic frame_start, // frame pulse
    input wire logic line_start, // line pulse
    input wire logic pixel_req, // pixel pulse
    input wire logic [owf_pkg::OWF_MEM_AW-1:0] fetch_addr, // fetch address
    input wire logic fetch_valid, // line active
    input wire logic line_done, // line end pulse
    input wire logic scroll_wrap // wrap pulse
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////
    sequence s_wr_start;
        reg_wr && reg_addr == OWF_SCR_START_LO_OFS;
    endsequence
    sequence s_rd_start;
        reg_rd && reg_addr == OWF_SCR_START_LO_OFS;
    endsequence
    property p_start_back;
        s_wr_start ##1 s_rd_start |=> reg_rdata == ($past(reg_wdata, 2) & 16'hfffc);
    endproperty
    a_start_back: assert property (p_start_back) else $error("scroll start readback wrong");
    property p_end_hi;
        $past(reg_rd) && $past(reg_addr) == OWF_SCR_END_HI_OFS |-> reg_rdata[15:4] == 12'h000;
    endproperty
    a_end_hi: assert property (p_end_hi) else $error("scroll end high has extra bits");
    property p_disp_lo;
        $past(reg_rd) && $past(reg_addr) == OWF_DISP_START_LO_OFS |-> reg_rdata[0] == 1'b0;
    endproperty
    a_disp_lo: assert property (p_disp_lo) else $error("display start bit 0 set");
    property p_line_ofs;
        $past(reg_rd) && $past(reg_addr) == OWF_LINE_OFS_OFS |-> (reg_rdata & 16'hf001) == 16'h0000;
    endproperty
    a_line_ofs: assert property (p_line_ofs) else $error("line offset unused bits set");
    property p_src_width;
        $past(reg_rd) && $past(reg_addr) == OWF_SRC_WIDTH_OFS |-> (reg_rdata & 16'hfe01) == 16'h0000;
    endproperty
    a_src_width: assert property (p_src_width) else $error("source width unused bits set");
    property p_pixel_step;
        fetch_valid && pixel_req && !frame_start |=>
            !fetch_valid || scroll_wrap || fetch_addr == $past(fetch_addr) + 20'h00002;
    endproperty
    a_pixel_step: assert property (p_pixel_step) else $error("pixel step not two bytes");
    property p_wrap_cause;
        scroll_wrap |-> $past(line_start) || $past(pixel_req);
    endproperty
    a_wrap_cause: assert property (p_wrap_cause) else $error("wrap without a step");
    property p_line_open;
        line_start && !fetch_valid && !frame_start |=> fetch_valid;
    endproperty
    a_line_open: assert property (p_line_open) else $error("line did not open");
    property p_done;
        line_done |-> !fetch_valid ##1 !line_done;
    endproperty
    a_done: assert property (p_done) else $error("line end pulse wrong");
endmodule
bind owf_fetch_addr owf_fetch_addr_chk owf_fetch_addr_chk_i (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_start(frame_start), .line_start(line_start), .pixel_req(pixel_req), .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid), .line_done(line_done), .scroll_wrap(scroll_wrap));
`default_nettype wire

// *** dv/owf_fetch_addr_test.sv ***
// owf_fetch_addr_test: self-checking bench of the overlay fetch address block.
// assumes owf_pkg and owf_fetch_addr compiled first; bench drives all ports.
`timescale 1ns/100ps
`default_nettype none
module owf_fetch_addr_test;
    import owf_pkg::*;
    logic clk, sys_rst, reg_wr, reg_rd, frame_start, line_start, pixel_req;
    logic [OWF_AW-1:0] reg_addr;
    logic [OWF_DW-1:0] reg_wdata, reg_rdata;
    logic [OWF_MEM_AW-1:0] fetch_addr, s_start, s_end;
    logic fetch_valid, line_done, scroll_wrap, rd_d, ev_d;
    logic [21:0] e;
    logic [15:0] rq[$];
    logic [21:0] fq[$]; // {wrap, done, address}
    wire logic [22:0] fobs;
    assign fobs = {scroll_wrap, line_done, fetch_valid, fetch_addr};
    int error_cnt = 0;
    int comparisons = 0;
    owf_fetch_addr owf_fetch_addr_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .frame_start(frame_start), .line_start(line_start), .pixel_req(pixel_req),
        .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .line_done(line_done), .scroll_wrap(scroll_wrap));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // strobes are set both ways each cycle so back-to-back accesses never have both strobes high at once
    task automatic wr(input logic [9:0] ad, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clk);
    endtask
    task automatic rd(input logic [9:0] ad, input logic [15:0] exp);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= ad;
        rq.push_back(exp);
        @(posedge clk);
    endtask
    task automatic idle();
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic set_addr(input logic [9:0] lo, input logic [19:0] v);
        wr(lo, v[15:0]);
        wr(lo + 10'h002, {12'h000, v[19:16]});
    endtask
    // returns {wrapped, address}; a carry out also counts as past the end
    function automatic logic [20:0] step(input logic [19:0] b, input logic [19:0] s);
        logic [20:0] t;
        t = {1'b0, b} + {1'b0, s};
        return (t > {1'b0, s_end}) ? {1'b1, s_start} : t;
    endfunction
    task automatic frame(input logic [19:0] ds, input logic [19:0] ofs, input int lines, input int n);
        logic [20:0] ls;
        logic [20:0] a;
        idle();
        wr(OWF_SRC_WIDTH_OFS, 16'(n * 2));
        wr(OWF_LINE_OFS_OFS, ofs[15:0]);
        set_addr(OWF_DISP_START_LO_OFS, ds);
        idle();
        frame_start <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        ls = {1'b0, ds};
        for (int l = 0; l < lines; l++)
        begin
            if (l > 0)
                ls = step(ls[19:0], ofs);
            line_start <= 1'b1;
            fq.push_back({ls[20], 1'b0, ls[19:0]});
            @(posedge clk);
            line_start <= 1'b0;
            a = ls;
            for (int p = 1; p <= n; p++)
            begin
                pixel_req <= 1'b1;
                a = step(a[19:0], 20'h00002);
                fq.push_back(p == n ? 22'h100000 : {a[20], 1'b0, a[19:0]});
                @(posedge clk);
            end
            pixel_req <= 1'b0;
            @(posedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        rd_d <= reg_rd;
        ev_d <= line_start | pixel_req;
    end
    always @(negedge clk)
    begin
        if (rd_d === 1'b1)
            check(reg_rdata, rq.pop_front());
        if (ev_d === 1'b1)
        begin
            e = fq.pop_front();
            if (e[20])
                check({line_done, fetch_valid}, 24'h2);
            else
                check(fobs, {e[21], 2'b01, e[19:0]});
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end
    initial
    begin
        logic [9:0] ads[8];
        logic [15:0] msk[8];
        logic [15:0] rst[8];
        logic [15:0] d;
        ads = '{10'h2b0, 10'h2b2, 10'h2b4, 10'h2b6, 10'h2b8, 10'h2ba, 10'h2bc, 10'h2be};
        msk = '{16'hfffc, 16'h000f, 16'hfffc, 16'h000f, 16'hfffe, 16'h000f, 16'h0ffe, 16'h01fe};
        rst = '{16'h0000, 16'h0000, 16'hfffc, 16'h000f, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        {sys_rst, reg_wr, reg_rd, frame_start, line_start, pixel_req} = 6'b100000;
        reg_addr = 10'h000;
        reg_wdata = 16'h0000;
        d = 16'($urandom(32'hadbd));
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(ads[i], rst[i]);
        rd(10'h2c0, 16'h0000);
        $display("test 1 reset values done");
        for (int i = 0; i < 8; i++)
        begin
            d = 16'($urandom);
            wr(ads[i], d);
            rd(ads[i], d & msk[i]);
        end
        wr(10'h2c0, 16'hffff);
        rd(10'h2c0, 16'h0000);
        $display("test 2 field widths done");
        s_start = 20'h00000;
        s_end = 20'hffffc;
        set_addr(OWF_SCR_START_LO_OFS, s_start);
        set_addr(OWF_SCR_END_LO_OFS, s_end);
        frame(20'($urandom) & 20'h7fffc, 20'h00010, 3, 4 + 2 * int'($urandom % 4));
        $display("test 3 plain frame done");
        s_start = 20'h00040;
        s_end = 20'h00104;
        set_addr(OWF_SCR_START_LO_OFS, s_start);
        set_addr(OWF_SCR_END_LO_OFS, s_end);
        frame(20'h000fc, 20'h00008, 3, 4);
        $display("test 4 scroll wrap done");
        repeat (3) @(posedge clk);
        conclude();
    end
endmodule
`default_nettype wire
